// file: verilog/ppic_regs.vh
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef PPIC_REGS_VH
`define PPIC_REGS_VH
// ==========================================================
// Register offsets (byte addresses = 4 x index)
`define PPIC_IDX_CLEAR0 8'hda
`define PPIC_IDX_SWEN 8'hdb
`define PPIC_IDX_MASK0 8'hdc
`define PPIC_IDX_CORE 8'hdd
`define PPIC_IDX_STACK 8'hde
`define PPIC_ADDR_CLEAR0 10'h368
`define PPIC_ADDR_SWEN 10'h36c
`define PPIC_ADDR_MASK0 10'h370
`define PPIC_ADDR_CORE 10'h374
`define PPIC_ADDR_STACK 10'h378
// ==========================================================
// Field positions and reset values
`define PPIC_SWEN_BIT 0
`define PPIC_GIE_BIT 0
`define PPIC_CLEAR0_RESET 8'h00
`define PPIC_SWEN_RESET 1'b0
`define PPIC_MASK0_RESET 8'h00
`define PPIC_FLAGS_RESET 8'h00
// ==========================================================
// Priorities and timing
`define PPIC_NUM_SRC 8
`define PPIC_FIRST_PRIO 5'h01
`define PPIC_ENTRY_CYCLES 13
`define PPIC_VEC_STEP 4
`endif

// file: verilog/ppic_prio_enc.v
// Priority encoder giving the vector of the highest-priority pending source
`timescale 1ns/1ps
module ppic_prio_enc #(
    parameter N = 8
) (
    input wire [N-1:0] pending_in,
    output reg any_out,
    output reg [7:0] vector_out,
    output reg [N-1:0] onehot_out
);
    integer i;
    // ==========================================================
    // Lowest index wins; scanning downward lets it overwrite
    always @* begin
        any_out = 1'b0;
        vector_out = 8'h00;
        onehot_out = {N{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pending_in[i]) begin
                any_out = 1'b1;
                vector_out = ((i[7:0] + 8'h01) << 2);
                onehot_out = {N{1'b0}};
                onehot_out[i] = 1'b1;
            end
        end
    end
endmodule // ppic_prio_enc

// file: verilog/ppic_post_latch.v
// Per-source posted latches with hardware post, software clear/post and take clear
`timescale 1ns/1ps
module ppic_post_latch #(
    parameter N = 8
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [N-1:0] hw_post_in,
    input wire [N-1:0] sw_post_in,
    input wire [N-1:0] sw_clear_in,
    input wire [N-1:0] take_clear_in,
    output wire [N-1:0] posted_out
);
    genvar g;
    // ==========================================================
    // One latch per source
    generate
        for (g = 0; g < N; g = g + 1) begin : g_src
            reg posted_reg;
            always @(posedge ref_clk_in) begin
                if (rst_in) begin
                    posted_reg <= 1'b0;
                end else if (ce_in) begin
                    // Post wins over any clear so no event is lost
                    if (hw_post_in[g] | sw_post_in[g]) begin
                        posted_reg <= 1'b1;
                    end else if (sw_clear_in[g] | take_clear_in[g]) begin
                        posted_reg <= 1'b0;
                    end
                end
            end
            assign posted_out[g] = posted_reg;
        end
    endgenerate
endmodule // ppic_post_latch

// file: verilog/ppic_ctrl.v
// Interrupt controller top: posting, masking, priority, CPU entry and return sequences
// Overview of operation
// - Activate on post, mask update, or enable
// - Finish current instruction before entry
// - Entry takes exactly 13 cycles
// - Push high PC, low PC, flags
// - Clear all flags, including global enable
// - Force upper PC byte to zero
// - Load encoder vector into low PC
// - Return pops flags, low PC, high PC
// - Pending interrupts served before next instruction
// - Encoder picks highest-priority pending source
// - Posted latch holds until taken or cleared
// - Pending needs post and mask; take needs enable
// - Mask never clears or blocks posting
// - Vector equals four times priority
// - Clear register reads posted bits
// - Enable low: write zero clears
// - Enable high: write one posts
// - Software enable resets to zero
// - Bits 7..0: I2C down to voltage monitor
// - Independent of vector-clear register
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "ppic_regs.vh"
module ppic_ctrl #(
    parameter N = `PPIC_NUM_SRC,
    parameter ENTRY_CYCLES = `PPIC_ENTRY_CYCLES
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire ce_in,
    // Wishbone classic slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [9:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    // Peripheral source conditions, bit 0 voltage monitor .. bit 7 I2C
    input wire [N-1:0] src_event_in,
    // CPU sequencer side
    input wire instr_done_in,
    input wire ret_req_in,
    input wire [7:0] stack_pop_data_in,
    output reg [15:0] prog_counter_out,
    output reg [7:0] flags_out,
    output reg stack_push_out,
    output reg stack_pop_out,
    output reg [7:0] stack_data_out,
    output reg entry_busy_out,
    output reg vector_start_out,
    output reg irq_request_out
);
    // ==========================================================
    // States
    localparam ST_RUN = 3'd0;
    localparam ST_ENTRY = 3'd1;
    localparam ST_RET = 3'd2;
    localparam [7:0] ENTRY_LAST = ENTRY_CYCLES - 1;
    // Outputs are registered, so the pulse is launched one cycle ahead of the last entry cycle
    localparam [7:0] VEC_CNT = ENTRY_LAST - 8'h01;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] cnt_reg;
    reg [7:0] cnt_next;
    reg [N-1:0] mask_reg;
    reg soft_irq_enable_reg;
    reg [7:0] prog_counter_low;
    reg [7:0] prog_counter_high;
    reg [7:0] saved_vector_reg;
    reg [N-1:0] src_meta_reg;
    reg [N-1:0] src_sync_reg;
    reg [N-1:0] src_prev_reg;

    wire [N-1:0] posted;
    wire [N-1:0] pending;
    wire [N-1:0] pending_ord;
    wire enc_any;
    wire [7:0] enc_vector;
    wire [N-1:0] enc_onehot;
    wire global_irq_enable;
    wire bus_req;
    wire bus_wr;
    wire [9:0] adr;
    wire [N-1:0] hw_post;
    wire [N-1:0] sw_post;
    wire [N-1:0] sw_clear;
    reg [N-1:0] take_clear;
    wire take;

    // ==========================================================
    // Source synchronisers and edge detection
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            src_meta_reg <= {N{1'b0}};
            src_sync_reg <= {N{1'b0}};
            src_prev_reg <= {N{1'b0}};
        end else if (ce_in) begin
            src_meta_reg <= src_event_in;
            src_sync_reg <= src_meta_reg;
            src_prev_reg <= src_sync_reg;
        end
    end
    // Edge, so a held source level posts once and a take can clear it
    assign hw_post = src_sync_reg & ~src_prev_reg;

    // ==========================================================
    // Register access
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_wr = bus_req & wb_we_in & wb_sel_in[0];
    assign adr = wb_adr_in;
    // Direct clear path; vector-clear logic has no part in it
    assign sw_clear = (bus_wr && adr == `PPIC_ADDR_CLEAR0 && !soft_irq_enable_reg) ?
                      ~wb_dat_in[N-1:0] : {N{1'b0}};
    assign sw_post = (bus_wr && adr == `PPIC_ADDR_CLEAR0 && soft_irq_enable_reg) ?
                     wb_dat_in[N-1:0] : {N{1'b0}};

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            mask_reg <= `PPIC_MASK0_RESET;
            soft_irq_enable_reg <= `PPIC_SWEN_RESET;
        end else if (ce_in) begin
            wb_ack_out <= bus_req;
            if (bus_wr && adr == `PPIC_ADDR_SWEN) begin
                soft_irq_enable_reg <= wb_dat_in[`PPIC_SWEN_BIT];
            end
            // Mask only gates; latches untouched
            if (bus_wr && adr == `PPIC_ADDR_MASK0) begin
                mask_reg <= wb_dat_in[N-1:0];
            end
            if (bus_req && !wb_we_in) begin
                case (adr)
                    `PPIC_ADDR_CLEAR0: wb_dat_out <= {{(32-N){1'b0}}, posted};
                    `PPIC_ADDR_SWEN: wb_dat_out <= {31'h0, soft_irq_enable_reg};
                    `PPIC_ADDR_MASK0: wb_dat_out <= {{(32-N){1'b0}}, mask_reg};
                    `PPIC_ADDR_CORE: wb_dat_out <= {8'h00, flags_out, prog_counter_out};
                    `PPIC_ADDR_STACK: wb_dat_out <= {24'h0, saved_vector_reg};
                    default: wb_dat_out <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_out <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Posting, masking and priority
    ppic_post_latch #(.N(N)) u_latch (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .hw_post_in(hw_post),
        .sw_post_in(sw_post),
        .sw_clear_in(sw_clear),
        .take_clear_in(take_clear),
        .posted_out(posted)
    );

    assign pending = posted & mask_reg;
    // Top two bits swap rank: I2C (bit 7) outranks sleep (bit 6)
    assign pending_ord = {pending[N-2], pending[N-1], pending[N-3:0]};

    ppic_prio_enc #(.N(N)) u_enc (
        .pending_in(pending_ord),
        .any_out(enc_any),
        .vector_out(enc_vector),
        .onehot_out(enc_onehot)
    );

    assign global_irq_enable = flags_out[`PPIC_GIE_BIT];
    // Combinational on mask, post and enable, so any of the three activates
    assign take = enc_any & global_irq_enable;

    // ==========================================================
    // Entry and return sequencer
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        take_clear = {N{1'b0}};
        case (state_reg)
            ST_RUN: begin
                // Checked ahead of return and before next fetch
                if (instr_done_in && take) begin
                    state_next = ST_ENTRY;
                    cnt_next = 8'h00;
                end else if (instr_done_in && ret_req_in) begin
                    state_next = ST_RET;
                    cnt_next = 8'h00;
                end
            end
            ST_ENTRY: begin
                if (cnt_reg == 8'h03) begin
                    take_clear = {enc_onehot[N-2], enc_onehot[N-1], enc_onehot[N-3:0]};
                end
                if (cnt_reg == ENTRY_LAST) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            ST_RET: begin
                if (cnt_reg == 8'h02) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_RUN;
            cnt_reg <= 8'h00;
            prog_counter_out <= 16'h0000;
            flags_out <= `PPIC_FLAGS_RESET;
            stack_push_out <= 1'b0;
            stack_pop_out <= 1'b0;
            stack_data_out <= 8'h00;
            entry_busy_out <= 1'b0;
            vector_start_out <= 1'b0;
            irq_request_out <= 1'b0;
            saved_vector_reg <= 8'h00;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            stack_push_out <= 1'b0;
            stack_pop_out <= 1'b0;
            vector_start_out <= 1'b0;
            irq_request_out <= take;
            entry_busy_out <= (state_next == ST_ENTRY);
            if (bus_wr && adr == `PPIC_ADDR_CORE && state_reg == ST_RUN) begin
                flags_out <= wb_dat_in[23:16];
            end
            case (state_reg)
                ST_ENTRY: begin
                    case (cnt_reg)
                        8'h00: begin
                            stack_push_out <= 1'b1;
                            stack_data_out <= prog_counter_out[15:8];
                        end
                        8'h01: begin
                            stack_push_out <= 1'b1;
                            stack_data_out <= prog_counter_out[7:0];
                        end
                        8'h02: begin
                            stack_push_out <= 1'b1;
                            stack_data_out <= flags_out;
                            flags_out <= 8'h00;
                        end
                        8'h03: begin
                            prog_counter_out[15:8] <= 8'h00;
                            prog_counter_out[7:0] <= enc_vector;
                            saved_vector_reg <= enc_vector;
                        end
                        default: begin
                            stack_data_out <= stack_data_out;
                        end
                    endcase
                    if (cnt_reg == VEC_CNT) begin
                        vector_start_out <= 1'b1;
                    end
                end
                ST_RET: begin
                    // Three bytes read, three pops, so the stack stays balanced
                    stack_pop_out <= 1'b1;
                    case (cnt_reg)
                        8'h00: flags_out <= stack_pop_data_in;
                        8'h01: prog_counter_out[7:0] <= stack_pop_data_in;
                        default: prog_counter_out[15:8] <= stack_pop_data_in;
                    endcase
                end
                default: begin
                    stack_data_out <= stack_data_out;
                end
            endcase
        end
    end
endmodule // ppic_ctrl

// file: verification/ppic_ctrl_props.sv
// Checker of the interrupt controller entry and return timing
`timescale 1ns/1ps
module ppic_ctrl_props (
    input wire ref_clk_in,
    input wire rst_in,
    input wire instr_done_in,
    input wire [15:0] prog_counter_out,
    input wire [7:0] flags_out,
    input wire stack_push_out,
    input wire stack_pop_out,
    input wire entry_busy_out,
    input wire vector_start_out,
    input wire irq_request_out
);
    // ========
    // Entry length counter, longer than a repetition may span
    reg [4:0] busy_cnt_reg;
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            busy_cnt_reg <= 5'h00;
        end else begin
            busy_cnt_reg <= entry_busy_out ? busy_cnt_reg + 5'h01 : 5'h00;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ========
    // Properties
    AST_ENTRY_LEN: assert property ($fell(entry_busy_out) |-> busy_cnt_reg == 5'h0d)
        else $error("entry length wrong");
    AST_VEC_LAST: assert property (vector_start_out |-> entry_busy_out && busy_cnt_reg == 5'h0c)
        else $error("vector start off its cycle");
    AST_PUSH_SEQ: assert property ($rose(entry_busy_out) |=>
        stack_push_out ##1 stack_push_out ##1 stack_push_out ##1 !stack_push_out)
        else $error("push sequence wrong");
    AST_PUSH_IN_ENTRY: assert property (stack_push_out |-> entry_busy_out)
        else $error("push outside entry");
    AST_FLAGS_CLR: assert property ($rose(entry_busy_out) |-> ##4 (flags_out == 8'h00) [*8])
        else $error("flags not cleared");
    AST_PC_VEC: assert property (vector_start_out |-> prog_counter_out[15:8] == 8'h00 &&
        prog_counter_out[1:0] == 2'h0 && prog_counter_out[7:0] inside {[8'h04:8'h20]})
        else $error("vector address wrong");
    AST_TAKE_CAUSE: assert property ($rose(entry_busy_out) |->
        $past(irq_request_out) && $past(instr_done_in) && $past(flags_out[0]))
        else $error("entry without cause");
    AST_POP_SEQ: assert property ($rose(stack_pop_out) |=> stack_pop_out ##1 stack_pop_out ##1 !stack_pop_out)
        else $error("pop sequence wrong");
    cover property ($rose(entry_busy_out));
    cover property ($rose(stack_pop_out));
    cover property (vector_start_out);
endmodule // ppic_ctrl_props
bind ppic_ctrl ppic_ctrl_props u_props (.ref_clk_in, .rst_in, .instr_done_in, .prog_counter_out, .flags_out,
    .stack_push_out, .stack_pop_out, .entry_busy_out, .vector_start_out, .irq_request_out);

// file: verification/ppic_cpu_model.sv
// Behavioural CPU sequencer with a byte stack
`timescale 1ns/1ps
module ppic_cpu_model (
    input wire ref_clk_in,
    input wire rst_in,
    input wire ret_cmd_in,
    input wire busy_in,
    input wire stack_push_in,
    input wire [7:0] stack_data_in,
    input wire stack_pop_in,
    output wire instr_done_out,
    output wire ret_req_out,
    output wire [7:0] pop_data_out
);
    // ========
    // Pacing and stack
    reg [1:0] phase_reg;
    reg ret_pend_reg;
    reg [7:0] mem [0:7];
    reg [2:0] sp;
    // Three-cycle instructions; none finishes while the entry runs
    assign instr_done_out = (phase_reg == 2'h2) && !busy_in;
    assign ret_req_out = ret_pend_reg && instr_done_out;
    // Empty stack shows the inverse of its bottom byte, never a held value
    // A pop seen this cycle has not yet moved the pointer, so look one byte deeper
    assign pop_data_out = (sp == 3'h0) ? ~mem[0] : mem[sp - 3'h1 - {2'b00, stack_pop_in}];
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            phase_reg <= 2'h0;
            ret_pend_reg <= 1'b0;
            sp <= 3'h0;
        end else begin
            phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
            if (ret_cmd_in) begin
                ret_pend_reg <= 1'b1;
            end else if (instr_done_out) begin
                ret_pend_reg <= 1'b0;
            end
            if (stack_push_in) begin
                mem[sp] <= stack_data_in;
                sp <= sp + 3'h1;
            end else if (stack_pop_in) begin
                sp <= sp - 3'h1;
            end
        end
    end
endmodule // ppic_cpu_model

// file: verification/tb_top.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "ppic_regs.vh"
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [9:0] adr = 10'h000;
    reg [31:0] wd = 32'h0;
    reg [7:0] src = 8'h00;
    reg ret_cmd = 1'b0;
    reg [31:0] rd;
    reg [7:0] rem;
    wire [31:0] rd_w;
    wire ack, done, rreq, push, pop, busy, vstart;
    wire [7:0] popd, sdat, flags;
    wire [15:0] pc;
    integer n_errors = 0;
    integer tests_run = 0;
    integer i;
    always #5 clk = ~clk;
    ppic_ctrl u_dut (.ref_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rd_w), .wb_ack_out(ack),
        .src_event_in(src), .instr_done_in(done), .ret_req_in(rreq), .stack_pop_data_in(popd),
        .prog_counter_out(pc), .flags_out(flags), .stack_push_out(push), .stack_pop_out(pop),
        .stack_data_out(sdat), .entry_busy_out(busy), .vector_start_out(vstart), .irq_request_out());
    ppic_cpu_model u_cpu (.ref_clk_in(clk), .rst_in(rst), .ret_cmd_in(ret_cmd), .busy_in(busy),
        .stack_push_in(push), .stack_data_in(sdat), .stack_pop_in(pop), .instr_done_out(done),
        .ret_req_out(rreq), .pop_data_out(popd));
    // ========
    // Tasks
    task chk(input [8*12:1] nm, input [31:0] exp, input [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    // Waits for ack without assuming its latency
    task wb(input w, input [9:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wd <= d;
            @(posedge clk);
            while (ack !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            rd = rd_w;
            cyc <= 1'b0;
            if (n >= 50) chk("wb ack", 1, 0);
        end
    endtask
    task rdc(input [9:0] a, input [31:0] exp, input [8*12:1] nm);
        begin
            wb(1'b0, a, 32'h0);
            chk(nm, exp, rd);
        end
    endtask
    task report_and_stop;
        begin
            $display("errors %0d checks %0d", n_errors, tests_run);
            if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #300000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    // ========
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdc(`PPIC_ADDR_CLEAR0, 32'h0, "clear0 rst");
        rdc(`PPIC_ADDR_SWEN, 32'h0, "swen rst");
        rdc(`PPIC_ADDR_MASK0, 32'h0, "mask rst");
        rdc(10'h3fc, 32'h0, "unmapped");
        $display("test reset done");
        src <= 8'h10;
        repeat (6) @(posedge clk);
        src <= 8'h00;
        rdc(`PPIC_ADDR_CLEAR0, 32'h10, "hw post");
        wb(1'b1, `PPIC_ADDR_CLEAR0, 32'hff);
        rdc(`PPIC_ADDR_CLEAR0, 32'h10, "write ones");
        wb(1'b1, `PPIC_ADDR_CLEAR0, 32'hef);
        rdc(`PPIC_ADDR_CLEAR0, 32'h0, "write zero");
        $display("test clear done");
        wb(1'b1, `PPIC_ADDR_SWEN, 32'h1);
        wb(1'b1, `PPIC_ADDR_CLEAR0, 32'h0);
        rdc(`PPIC_ADDR_CLEAR0, 32'h0, "sw zero");
        wb(1'b1, `PPIC_ADDR_CLEAR0, 32'hff);
        wb(1'b1, `PPIC_ADDR_SWEN, 32'h0);
        rdc(`PPIC_ADDR_CLEAR0, 32'hff, "sw post");
        $display("test soft done");
        // Globally enabled but masked: nothing may be taken
        wb(1'b1, `PPIC_ADDR_CORE, 32'h00010000);
        repeat (20) @(posedge clk);
        chk("masked", 0, busy);
        rem = 8'hff;
        wb(1'b1, `PPIC_ADDR_MASK0, 32'hff);
        // Each return re-enables, so the next one is taken at once
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            while (vstart !== 1'b1 && tests_run < 100000) @(posedge clk);
            chk("vector", (i + 1) * 4, pc);
            chk("flags", 0, flags);
            chk("pushed flag", 1, u_cpu.mem[u_cpu.sp - 3'h1]);
            rem[(i < 6) ? i : 13 - i] = 1'b0;
            rdc(`PPIC_ADDR_CLEAR0, rem, "taken");
            ret_cmd <= 1'b1;
            @(posedge clk);
            ret_cmd <= 1'b0;
        end
        repeat (30) @(posedge clk);
        chk("gie back", 1, flags[0]);
        $display("test take done");
        report_and_stop;
    end
endmodule // tb_top
